// ### verilog/port_power_cfg.svh
// How it works
// (R1) each downstream port uses one two-way pin for power switching and fault sense
// (R2) in ganged mode one shared pin powers and senses all downstream ports
// (R3) ganged mode is chosen by a configuration bit loaded from outside
// (R4) a fault on the shared pin marks every downstream port as overcurrent
// (R5) the board ties every external power switch to the shared pin when ganged
// (R6) individual mode is the mode after reset
// (R7) power off: pin driven low and its pull-up switched off
// (R8) power on: driver released and pull-up enabled, pin acts open-drain
// (R9) the external switch pulls the pin low on overcurrent
// (R10) a low pin level reads as a fault; the released driver does not disturb it
// (R11) the sensed level is filtered so power-up transients do not trip detection
// (R12) while a port is powered its pin is sampled every sampling period
// (R13) consecutive low samples lasting the single-pulse width flag overcurrent
// (R14) two separate low groups inside the double-pulse window flag overcurrent
// (R15) single-pulse width is four bits, 1 ms steps, 0 to 15 ms, default 0101
// (R16) double-pulse window is eight bits in 1 ms steps, default 14h
// (R17) for the lockout time after power-on the pin is ignored
// (R18) lockout time is eight bits in 1 ms steps, default 0Ah
// (R19) software never programs window or lockout to zero
// (R20) window opens at the first low group; expiry drops the pending pulse
// (R21) fixed prescaler makes the 1 ms tick; timers restart at power-on
`ifndef PORT_POWER_CFG_SVH
`define PORT_POWER_CFG_SVH

`define PP_NUM_PORTS        6
`define PP_NUM_SENSE        7

// register indices; byte address is four times the index
`define PP_IDX_LOCKOUT      14'h30E1
`define PP_IDX_MIN_WIDTH    14'h30EA
`define PP_IDX_WINDOW       14'h30EB
`define PP_IDX_CONTROL      14'h30F0
`define PP_IDX_STATUS       14'h30F1
`define PP_IDX_PIN_LEVEL    14'h30F2

`define PP_RST_LOCKOUT      8'h0A
`define PP_RST_MIN_WIDTH    4'h5
`define PP_RST_WINDOW       8'h14

`define PP_CTRL_PWR_LSB     0
`define PP_CTRL_GANG_BIT    8

// millisecond timebase
`define PP_TICK_NS          1000000
`define PP_CLK_NS           4
`define PP_TICK_CYCLES      (`PP_TICK_NS / `PP_CLK_NS)

`endif

// ### verilog/port_power_pkg.sv
package port_power_pkg;

	typedef logic [5:0] port_vec_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DATA = 2'b10
	} bus_state_t;

endpackage

// ### verilog/port_oc_detector.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_power_cfg.svh"

module port_oc_detector (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// timebase and control
	input  wire logic       ms_tick,
	input  wire logic       power_on,
	input  wire logic       pin_low,
	// timing settings
	input  wire logic [3:0] min_width,
	input  wire logic [7:0] window,
	input  wire logic [7:0] lockout,
	// one-cycle fault pulse
	output logic            oc_event
);

	logic       power_q;
	logic       power_rise;
	logic [7:0] lock_q;
	logic [3:0] low_cnt_q;
	logic       prev_low_q;
	logic       pending_q;
	logic [7:0] win_q;
	logic       sample_en;
	logic       single_hit;
	logic       new_group;
	logic       double_hit;

	assign power_rise = power_on & ~power_q;
	// samples only count once the lockout has run out
	assign sample_en  = ms_tick & power_on & ~power_rise & (lock_q == 8'h00); // R12 R17
	assign single_hit = sample_en & pin_low & (low_cnt_q == min_width); // R13
	assign new_group  = sample_en & pin_low & ~prev_low_q;
	assign double_hit = new_group & pending_q; // R14

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			power_q <= 1'b0;
		end else begin
			power_q <= power_on;
		end
	end

	// a zero lockout would open sensing at once; software keeps it nonzero
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lock_q <= 8'h00;
		end else if (!power_on) begin
			lock_q <= 8'h00;
		end else if (power_rise) begin
			lock_q <= lockout; // R17 R21
		end else if (ms_tick && lock_q != 8'h00) begin
			lock_q <= lock_q - 8'h01;
		end
	end

	// saturating run length of low samples
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			low_cnt_q  <= 4'h0;
			prev_low_q <= 1'b0;
		end else if (!power_on || power_rise) begin
			low_cnt_q  <= 4'h0; // R21
			prev_low_q <= 1'b0;
		end else if (sample_en) begin
			prev_low_q <= pin_low;
			if (!pin_low) begin
				low_cnt_q <= 4'h0;
			end else if (low_cnt_q != 4'hF) begin
				low_cnt_q <= low_cnt_q + 4'h1; // R13
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pending_q <= 1'b0;
			win_q     <= 8'h00;
		end else if (!power_on || power_rise) begin
			pending_q <= 1'b0; // R21
			win_q     <= 8'h00;
		end else if (double_hit || single_hit) begin
			pending_q <= 1'b0;
		end else if (new_group) begin
			pending_q <= 1'b1; // R20
			win_q     <= window;
		end else if (ms_tick && pending_q) begin
			if (win_q <= 8'h01) begin
				pending_q <= 1'b0; // R20
			end
			win_q <= win_q - 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			oc_event <= 1'b0;
		end else begin
			oc_event <= single_hit | double_hit; // R13 R14
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_lockout_blocks: assert property ((lock_q != 8'h00) |=> !oc_event) // R17
		else $error("fault flagged during lockout");
	a_window_expiry: assert property ((pending_q && ms_tick && win_q == 8'h01 && !new_group && power_on
		&& !power_rise && !single_hit) |=> !pending_q) // R20
		else $error("pending pulse kept after window end");
	a_single_width: assert property ((sample_en && pin_low && low_cnt_q == min_width) |=> oc_event) // R13
		else $error("long low pulse not flagged");
	a_double_group: assert property ((pending_q && new_group) |=> (oc_event && !pending_q)) // R14
		else $error("second low group not flagged");
	a_restart_on: assert property (power_rise |=> (lock_q == $past(lockout) && low_cnt_q == 4'h0)) // R21
		else $error("timers not restarted at power-on");

endmodule
`default_nettype wire

// ### verilog/port_power_overcurrent_control.sv
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "port_power_cfg.svh"

module port_power_overcurrent_control #(
	parameter int TICK_CYCLES = `PP_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// per-port power and sense pins
	input  wire logic [5:0]  port_power_sense_pin_i,
	output logic      [5:0]  port_power_sense_pin_o,
	output logic      [5:0]  port_power_sense_pin_oe_n,
	output logic      [5:0]  port_power_sense_pullup_en,
	// shared pin for ganged mode
	input  wire logic        shared_power_sense_pin_i,
	output logic             shared_power_sense_pin_o,
	output logic             shared_power_sense_pin_oe_n,
	output logic             shared_power_sense_pullup_en
);

	// ************************************************************
	// declarations
	// ************************************************************
	port_power_pkg::bus_state_t bus_q;
	logic [13:0]                idx_q;
	logic                       wr_q;
	logic                       take;
	logic [7:0]                 lockout_q;
	logic [3:0]                 min_width_q;
	logic [7:0]                 window_q;
	port_power_pkg::port_vec_t  port_pwr_q;
	logic                       gang_q;
	port_power_pkg::port_vec_t  oc_status_q;
	port_power_pkg::port_vec_t  oc_set;
	port_power_pkg::port_vec_t  oc_clr;
	logic [6:0]                 pin_q1;
	logic [6:0]                 pin_q2;
	logic [6:0]                 pin_low;
	logic [6:0]                 power_on;
	logic [6:0]                 oc_event;
	logic [17:0]                presc_q;
	logic                       tick_q;
	port_power_pkg::port_vec_t  pwr_eff;
	logic                       shared_pwr;
	logic                       wr_now;
	logic [31:0]                rd_data;

	// ************************************************************
	// ahb-lite slave, one wait state on every transfer
	// ************************************************************
	assign take   = hsel & htrans[1] & hready;
	assign wr_now = (bus_q == port_power_pkg::BUS_DATA) & wr_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			bus_q     <= port_power_pkg::BUS_IDLE;
			idx_q     <= 14'h0000;
			wr_q      <= 1'b0;
			hreadyout <= 1'b1;
		end else begin
			case (bus_q)
				port_power_pkg::BUS_IDLE: begin
					if (take) begin
						bus_q     <= port_power_pkg::BUS_DATA;
						idx_q     <= haddr[15:2];
						wr_q      <= hwrite;
						hreadyout <= 1'b0;
					end
				end
				port_power_pkg::BUS_DATA: begin
					bus_q     <= port_power_pkg::BUS_IDLE;
					hreadyout <= 1'b1;
				end
				default: begin
					bus_q     <= port_power_pkg::BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// only the okay response is ever given
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (idx_q)
			`PP_IDX_LOCKOUT:   rd_data = {24'h00_0000, lockout_q};
			`PP_IDX_MIN_WIDTH: rd_data = {28'h000_0000, min_width_q};
			`PP_IDX_WINDOW:    rd_data = {24'h00_0000, window_q};
			`PP_IDX_CONTROL:   rd_data = {23'h00_0000, gang_q, 2'h0, port_pwr_q};
			`PP_IDX_STATUS:    rd_data = {26'h000_0000, oc_status_q};
			`PP_IDX_PIN_LEVEL: rd_data = {25'h000_0000, pin_low};
			default:           rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (bus_q == port_power_pkg::BUS_DATA && !wr_q) begin
			hrdata <= rd_data;
		end
	end

	// ************************************************************
	// timing registers
	// ************************************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lockout_q   <= `PP_RST_LOCKOUT; // R18
			min_width_q <= `PP_RST_MIN_WIDTH; // R15
			window_q    <= `PP_RST_WINDOW; // R16
		end else if (wr_now) begin
			if (idx_q == `PP_IDX_LOCKOUT) begin
				lockout_q <= hwdata[7:0]; // R18
			end
			if (idx_q == `PP_IDX_MIN_WIDTH) begin
				min_width_q <= hwdata[3:0]; // R15
			end
			if (idx_q == `PP_IDX_WINDOW) begin
				window_q <= hwdata[7:0]; // R16
			end
		end
	end

	// ************************************************************
	// control: port power and mode select
	// ************************************************************
	// the gang bit stands in for the externally loaded configuration
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			port_pwr_q <= 6'h00;
			gang_q     <= 1'b0; // R6
		end else if (wr_now && idx_q == `PP_IDX_CONTROL) begin
			port_pwr_q <= hwdata[`PP_CTRL_PWR_LSB +: 6];
			gang_q     <= hwdata[`PP_CTRL_GANG_BIT]; // R3
		end
	end

	// ganged: any power bit powers the shared line, port pins stay off
	assign shared_pwr = gang_q & (|port_pwr_q); // R2
	assign pwr_eff    = gang_q ? 6'h00 : port_pwr_q; // R1 R2

	// ************************************************************
	// pin drivers
	// ************************************************************
	// power off drives a hard low with no pull-up; power on lets go
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			port_power_sense_pin_o     <= 6'h00;
			port_power_sense_pin_oe_n  <= 6'h00;
			port_power_sense_pullup_en <= 6'h00;
		end else begin
			port_power_sense_pin_o     <= 6'h00; // R7
			port_power_sense_pin_oe_n  <= pwr_eff; // R7 R8
			port_power_sense_pullup_en <= pwr_eff; // R8
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shared_power_sense_pin_o     <= 1'b0;
			shared_power_sense_pin_oe_n  <= 1'b0;
			shared_power_sense_pullup_en <= 1'b0;
		end else begin
			shared_power_sense_pin_o     <= 1'b0; // R7
			shared_power_sense_pin_oe_n  <= shared_pwr; // R7 R8
			shared_power_sense_pullup_en <= shared_pwr; // R8
		end
	end

	// ************************************************************
	// sense filtering
	// ************************************************************
	// two-cycle agreement rejects single-cycle glitches on the
	// slow-ramping line; the millisecond sampling does the rest
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_q1 <= 7'h7F;
			pin_q2 <= 7'h7F;
		end else begin
			pin_q1 <= {shared_power_sense_pin_i, port_power_sense_pin_i}; // R10
			pin_q2 <= pin_q1;
		end
	end

	// low only when both samples agree; own driver is released while sensing
	assign pin_low = ~pin_q1 & ~pin_q2; // R10 R11

	// ************************************************************
	// millisecond timebase
	// ************************************************************
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			presc_q <= 18'h00000;
			tick_q  <= 1'b0;
		end else if (presc_q == 18'(TICK_CYCLES - 1)) begin
			presc_q <= 18'h00000; // R21
			tick_q  <= 1'b1;
		end else begin
			presc_q <= presc_q + 18'h00001;
			tick_q  <= 1'b0;
		end
	end

	// ************************************************************
	// detectors: six ports plus the shared line
	// ************************************************************
	assign power_on = {shared_pwr, pwr_eff};

	generate
		for (genvar i = 0; i < `PP_NUM_SENSE; i++) begin : g_det
			port_oc_detector u_det (
				.clk_sys   (clk_sys),
				.resetn    (resetn),
				.ms_tick   (tick_q),
				.power_on  (power_on[i]),
				.pin_low   (pin_low[i]),
				.min_width (min_width_q),
				.window    (window_q),
				.lockout   (lockout_q),
				.oc_event  (oc_event[i])
			);
		end
	endgenerate

	// ************************************************************
	// overcurrent status, write one to clear
	// ************************************************************
	assign oc_set = oc_event[5:0] | {6{oc_event[6]}}; // R4
	assign oc_clr = (wr_now && idx_q == `PP_IDX_STATUS) ? hwdata[5:0] : 6'h00;

	// a fault arriving with its clear still sets the bit
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			oc_status_q <= 6'h00;
		end else begin
			oc_status_q <= (oc_status_q & ~oc_clr) | oc_set; // R4 R13 R14
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_taken;
		bus_q == port_power_pkg::BUS_IDLE && take;
	endsequence

	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	a_bus_one_wait: assert property (s_taken |=> s_one_wait)
		else $error("transfer did not take exactly one wait state");
	a_pin_driven_low: assert property (port_power_sense_pin_o == 6'h00 && !shared_power_sense_pin_o) // R7
		else $error("pin driven high");
	a_pullup_release: assert property ((port_power_sense_pullup_en == port_power_sense_pin_oe_n)
		&& (shared_power_sense_pullup_en == shared_power_sense_pin_oe_n)) // R7 R8
		else $error("pull-up and release disagree");
	a_gang_ports_off: assert property (gang_q |=> port_power_sense_pin_oe_n == 6'h00) // R2
		else $error("port pin released in ganged mode");
	a_gang_marks_all: assert property (oc_event[6] |=> oc_status_q == 6'h3F) // R4
		else $error("shared fault did not mark every port");
	a_set_beats_clear: assert property ((oc_set != 6'h00) |=> ((oc_status_q & $past(oc_set)) == $past(oc_set)))
		else $error("fault lost against clear");
	a_tick_spacing: assert property (tick_q |=> !tick_q) // R21
		else $error("tick spacing wrong");
	a_off_no_event: assert property (!power_on[0] |=> !oc_event[0]) // R12
		else $error("fault flagged on unpowered port");

endmodule
`default_nettype wire

// ### test/power_switch_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************
// external power switch on each line
// ********************************
module power_switch_model (
	// clock
	input  wire logic       clk_sys,
	// fault command per line, bit 6 is the shared line
	input  wire logic [6:0] fault_req,
	// device side of each line
	input  wire logic [6:0] drive_o,
	input  wire logic [6:0] drive_oe_n,
	input  wire logic [6:0] pullup_en,
	// resolved wire level
	output logic      [6:0] pin_level
);
	logic float_q = 1'b0;

	// an undriven line without pull-up must not hold a stale value
	always_ff @(posedge clk_sys) begin
		float_q <= ~float_q;
	end

	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (fault_req[i]) begin
				pin_level[i] = 1'b0;
			end else if (!drive_oe_n[i]) begin
				pin_level[i] = drive_o[i];
			end else if (pullup_en[i]) begin
				pin_level[i] = 1'b1;
			end else begin
				pin_level[i] = float_q;
			end
		end
	end
endmodule

`default_nettype wire

// ### test/port_power_overcurrent_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_power_cfg.svh"

module port_power_overcurrent_control_tb;
	// ********************************
	// signals
	// ********************************
	localparam logic [31:0] A_LOCK = {16'h0000, `PP_IDX_LOCKOUT, 2'b00};
	localparam logic [31:0] A_MINW = {16'h0000, `PP_IDX_MIN_WIDTH, 2'b00};
	localparam logic [31:0] A_WIN  = {16'h0000, `PP_IDX_WINDOW, 2'b00};
	localparam logic [31:0] A_CTRL = {16'h0000, `PP_IDX_CONTROL, 2'b00};
	localparam logic [31:0] A_STAT = {16'h0000, `PP_IDX_STATUS, 2'b00};
	localparam logic [31:0] A_PINS = {16'h0000, `PP_IDX_PIN_LEVEL, 2'b00};
	typedef struct {logic wr; logic [31:0] addr; logic [31:0] wdata; logic [31:0] exp;} row_t;
	logic        clk_sys   = 1'b0;
	logic        resetn    = 1'b0;
	logic        hsel      = 1'b0;
	logic        hwrite    = 1'b0;
	logic [1:0]  htrans    = 2'h0;
	logic [2:0]  hsize     = 3'h2;
	logic [31:0] haddr     = 32'h0;
	logic [31:0] hwdata    = 32'h0;
	logic [6:0]  fault_req = 7'h00;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [31:0] pins;
	logic        hreadyout;
	logic        hresp;
	logic [5:0]  p_o;
	logic [5:0]  p_oe_n;
	logic [5:0]  p_pu;
	logic        s_o;
	logic        s_oe_n;
	logic        s_pu;
	logic [6:0]  lvl;
	int          errors    = 0;
	int          cmp_count = 0;
	row_t rows [9] = '{
		'{1'b0, A_LOCK, 32'h0, 32'h0000000A},
		'{1'b0, A_MINW, 32'h0, 32'h00000005},
		'{1'b0, A_WIN,  32'h0, 32'h00000014},
		'{1'b0, A_CTRL, 32'h0, 32'h00000000},
		'{1'b0, A_STAT, 32'h0, 32'h00000000},
		'{1'b1, 32'h0000C3D0, 32'hFFFFFFFF, 32'h00000000},
		'{1'b1, A_MINW, 32'h000000F3, 32'h00000003},
		'{1'b1, A_WIN,  32'h00000005, 32'h00000005},
		'{1'b1, A_LOCK, 32'h00000006, 32'h00000006}
	};

	assign pins = {11'h000, p_o, p_oe_n, p_pu, s_o, s_oe_n, s_pu};

	port_power_overcurrent_control #(.TICK_CYCLES(8)) DUT (
		.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .port_power_sense_pin_i(lvl[5:0]),
		.port_power_sense_pin_o(p_o), .port_power_sense_pin_oe_n(p_oe_n),
		.port_power_sense_pullup_en(p_pu), .shared_power_sense_pin_i(lvl[6]),
		.shared_power_sense_pin_o(s_o), .shared_power_sense_pin_oe_n(s_oe_n),
		.shared_power_sense_pullup_en(s_pu)
	);

	power_switch_model switch_model (
		.clk_sys(clk_sys), .fault_req(fault_req), .drive_o({s_o, p_o}),
		.drive_oe_n({s_oe_n, p_oe_n}), .pullup_en({s_pu, p_pu}), .pin_level(lvl)
	);

	// ********************************
	// tasks
	// ********************************
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// no cycle count assumed; only the bound ends a stuck wait
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("mismatch hreadyout expected 1 seen stuck");
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= addr;
		hwrite <= wr;
		wait_ready;
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wdata;
		wait_ready;
		rd = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic rdc(input string name, input logic [31:0] addr, input logic [31:0] exp);
		bus(1'b0, addr, 32'h0);
		check(name, rd, exp);
	endtask

	task automatic poll(input logic [31:0] exp);
		int n;
		n = 0;
		do begin
			bus(1'b0, A_STAT, 32'h0);
			n++;
		end while (rd !== exp && n < 60);
		check("status", rd, exp);
	endtask

	task automatic pulse(input logic [6:0] m, input int n);
		@(posedge clk_sys);
		fault_req <= m;
		repeat (n) @(posedge clk_sys);
		fault_req <= 7'h00;
	endtask

	// ********************************
	// stimulus
	// ********************************
	initial forever #2 clk_sys = ~clk_sys;

	initial begin
		#20000;
		errors++;
		$display("mismatch watchdog expected done seen timeout");
		complete_run;
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		check("pins in reset", pins, 32'h0);
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr)
				bus(1'b1, rows[i].addr, rows[i].wdata);
			rdc("register", rows[i].addr, rows[i].exp);
		end
		$display("test registers done");

		bus(1'b1, A_CTRL, 32'h00000001);
		fault_req <= 7'h01;
		repeat (2) @(posedge clk_sys);
		check("pins port0 on", pins, {11'h000, 6'h00, 6'h01, 6'h01, 3'b000});
		// two low groups inside the lockout would trip the double-pulse rule if sensed
		repeat (8) @(posedge clk_sys);
		fault_req <= 7'h00;
		repeat (10) @(posedge clk_sys);
		fault_req <= 7'h01;
		repeat (10) @(posedge clk_sys);
		fault_req <= 7'h00;
		repeat (96) @(posedge clk_sys);
		rdc("lockout status", A_STAT, 32'h0);
		$display("test lockout done");

		pulse(7'h01, 10);
		repeat (80) @(posedge clk_sys);
		pulse(7'h01, 10);
		rdc("lone pulse status", A_STAT, 32'h0);
		repeat (16) @(posedge clk_sys);
		pulse(7'h01, 10);
		poll(32'h00000001);
		bus(1'b1, A_STAT, 32'h0000003F);
		rdc("status cleared", A_STAT, 32'h0);
		$display("test double pulse done");

		// port 1 is unpowered, so its fault must stay invisible
		fault_req <= 7'h03;
		poll(32'h00000001);
		bus(1'b0, A_PINS, 32'h0);
		check("pin level", rd, 32'h0000007F);
		fault_req <= 7'h00;
		repeat (40) @(posedge clk_sys);
		bus(1'b1, A_STAT, 32'h0000003F);
		$display("test single pulse done");

		bus(1'b1, A_CTRL, 32'h00000101);
		repeat (2) @(posedge clk_sys);
		check("pins ganged", pins, {11'h000, 6'h00, 6'h00, 6'h00, 3'b011});
		repeat (96) @(posedge clk_sys);
		fault_req <= 7'h40;
		poll(32'h0000003F);
		fault_req <= 7'h00;
		bus(1'b1, A_CTRL, 32'h0);
		repeat (2) @(posedge clk_sys);
		check("pins ganged off", pins, 32'h0);
		$display("test ganged done");

		bus(1'b1, A_CTRL, 32'h00000001);
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check("pins second reset", pins, 32'h0);
		resetn <= 1'b1;
		rdc("lockout after reset", A_LOCK, 32'h0000000A);
		rdc("control after reset", A_CTRL, 32'h0);
		$display("test second reset done");
		complete_run;
	end
endmodule

`default_nettype wire
